// File: verilog/hfc_params.svh
`ifndef HFC_PARAMS_SVH
`define HFC_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define HFC_OFS_CPU_SRC     8'h49
`define HFC_OFS_SYS_SRC     8'h4A
`define HFC_OFS_ADC_CLK     8'h4B
`define HFC_OFS_IRQ_OVT     8'h4C
`define HFC_OFS_FAN_PIN     8'h4D

// ****************************************************************
// Reset values
// ****************************************************************
`define HFC_RST_CPU_SRC     8'h00
`define HFC_RST_SYS_SRC     8'h00
`define HFC_RST_ADC_CLK     8'h44
`define HFC_RST_IRQ_OVT     8'h10
`define HFC_RST_FAN_PIN     8'h05

// ****************************************************************
// Field positions
// ****************************************************************
`define HFC_CPU_SRC_LSB     0
`define HFC_SYS_SRC_LSB     5
`define HFC_ADC_SEL_LSB     4
`define HFC_ADC_RSV_LO_LSB  2
`define HFC_ADC_RSV_HI_LSB  6
`define HFC_CPU_IRQ_BIT     6
`define HFC_SYS_ONE_BIT     5
`define HFC_IRQ_RSV_BIT     4
`define HFC_OVT_DIS_BIT     3
`define HFC_OVT_POL_BIT     2
`define HFC_CPU_LVL_BIT     3
`define HFC_CPU_IN_BIT      2
`define HFC_SYS_LVL_BIT     1
`define HFC_SYS_IN_BIT      0

// ****************************************************************
// Timing
// ****************************************************************
`define HFC_REF_CLK_HZ      20000000
`define HFC_ADC_BASE_HZ     22500
`define HFC_ADC_BASE_CYC    (`HFC_REF_CLK_HZ / `HFC_ADC_BASE_HZ)
`define HFC_ADC_DIV_1       1
`define HFC_ADC_DIV_4       4
`define HFC_ADC_DIV_16      16
`define HFC_ADC_DIV_64      64

`endif

// File: verilog/hfc_pkg.sv
package hfc_pkg;

    typedef logic [11:0] hfc_cnt_t;

    typedef enum logic [2:0] {
        HFC_SRC_CPU,
        HFC_SRC_SYS,
        HFC_SRC_AGENT1,
        HFC_SRC_AGENT2,
        HFC_SRC_AGENT3,
        HFC_SRC_AGENT4
    } hfc_src_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } hfc_bus_s;

    typedef struct packed {
        logic [2:0] cpu_src_reg;
        hfc_src_e   cpu_src_eff;
        logic [2:0] sys_src_reg;
        hfc_src_e   sys_src_eff;
        logic [1:0] adc_sel;
        logic [1:0] adc_rsv_hi;
        logic [1:0] adc_rsv_lo;
        logic       cpu_irq_cmp;
        logic       sys_one_shot;
        logic       ovt_dis;
        logic       ovt_pol;
        logic       cpu_lvl;
        logic       cpu_in;
        logic       sys_lvl;
        logic       sys_in;
        logic       ovt_pin;
        logic       cpu_tach;
        logic       sys_tach;
        logic [7:0] rdata;
    } hfc_state_s;

    typedef struct packed {
        hfc_cnt_t cnt;
        logic     tick;
    } hfc_div_s;

endpackage

// File: verilog/hfc_tick_div.sv
`timescale 1ns/1ns
`include "hfc_params.svh"

// ****************************************************************
// Tick divider: one tick every period steps
// ****************************************************************
module hfc_tick_div (
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    input  wire logic              step,
    input  wire hfc_pkg::hfc_cnt_t period,
    output logic                   tick
);

    hfc_pkg::hfc_div_s st_ff;
    hfc_pkg::hfc_div_s nxt_st;

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.tick = 1'b0;
        if (step) begin
            // Compare with >= so a shortened period never strands the count
            if (st_ff.cnt >= hfc_pkg::hfc_cnt_t'(period - 12'h001)) begin
                nxt_st.cnt  = '0;
                nxt_st.tick = 1'b1;
            end else begin
                nxt_st.cnt = hfc_pkg::hfc_cnt_t'(st_ff.cnt + 12'h001);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick = st_ff.tick;

endmodule

// File: verilog/hfc_regs.sv
// Local design decision: the plain strobed port.
`timescale 1ns/1ns
`include "hfc_params.svh"

module hfc_regs (
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    input  wire hfc_pkg::hfc_bus_s bus,
    output logic [7:0]             rdata,
    input  wire logic              cpu_overtemp,
    output logic                   overtemp_pin,
    output hfc_pkg::hfc_src_e      cpu_fan_source_field,
    output hfc_pkg::hfc_src_e      system_fan_source_field,
    output logic                   adc_sample_tick,
    output logic                   cpu_temp_irq_mode,
    output logic                   system_temp_one_shot_enable,
    input  wire logic              cpu_fan_tach_pin_i,
    output logic                   cpu_fan_tach_pin_o,
    output logic                   cpu_fan_tach_pin_oe,
    output logic                   cpu_fan_tach,
    input  wire logic              system_fan_tach_pin_i,
    output logic                   system_fan_tach_pin_o,
    output logic                   system_fan_tach_pin_oe,
    output logic                   system_fan_tach
);

    localparam hfc_pkg::hfc_cnt_t BASE_CYC = hfc_pkg::hfc_cnt_t'(`HFC_ADC_BASE_CYC);

    localparam logic [7:0] RST_ADC = `HFC_RST_ADC_CLK;
    localparam logic [7:0] RST_IRQ = `HFC_RST_IRQ_OVT;
    localparam logic [7:0] RST_FAN = `HFC_RST_FAN_PIN;
    localparam logic [7:0] RST_CPU = `HFC_RST_CPU_SRC;
    localparam logic [7:0] RST_SYS = `HFC_RST_SYS_SRC;

    localparam hfc_pkg::hfc_state_s RST_ST = '{
        cpu_src_reg  : RST_CPU[`HFC_CPU_SRC_LSB +: 3],
        cpu_src_eff  : hfc_pkg::HFC_SRC_CPU,
        sys_src_reg  : RST_SYS[`HFC_SYS_SRC_LSB +: 3],
        sys_src_eff  : hfc_pkg::HFC_SRC_SYS,
        adc_sel      : RST_ADC[`HFC_ADC_SEL_LSB +: 2],
        adc_rsv_hi   : RST_ADC[`HFC_ADC_RSV_HI_LSB +: 2],
        adc_rsv_lo   : RST_ADC[`HFC_ADC_RSV_LO_LSB +: 2],
        cpu_irq_cmp  : RST_IRQ[`HFC_CPU_IRQ_BIT],
        sys_one_shot : RST_IRQ[`HFC_SYS_ONE_BIT],
        ovt_dis      : RST_IRQ[`HFC_OVT_DIS_BIT],
        ovt_pol      : RST_IRQ[`HFC_OVT_POL_BIT],
        cpu_lvl      : RST_FAN[`HFC_CPU_LVL_BIT],
        cpu_in       : RST_FAN[`HFC_CPU_IN_BIT],
        sys_lvl      : RST_FAN[`HFC_SYS_LVL_BIT],
        sys_in       : RST_FAN[`HFC_SYS_IN_BIT],
        ovt_pin      : 1'b1,
        cpu_tach     : 1'b0,
        sys_tach     : 1'b0,
        rdata        : 8'h00
    };

    hfc_pkg::hfc_state_s st_ff;
    hfc_pkg::hfc_state_s nxt_st;
    logic                base_tick;
    hfc_pkg::hfc_cnt_t   post_period;
    logic [7:0]          wd;
    logic                wr_cpu;
    logic                wr_sys;
    logic                wr_adc;
    logic                wr_irq;
    logic                wr_fan;

    assign wd     = bus.wdata;
    assign wr_cpu = bus.wr && (bus.addr == `HFC_OFS_CPU_SRC);
    assign wr_sys = bus.wr && (bus.addr == `HFC_OFS_SYS_SRC);
    assign wr_adc = bus.wr && (bus.addr == `HFC_OFS_ADC_CLK);
    assign wr_irq = bus.wr && (bus.addr == `HFC_OFS_IRQ_OVT);
    assign wr_fan = bus.wr && (bus.addr == `HFC_OFS_FAN_PIN);

    // ****************************************************************
    // Source decode
    // ****************************************************************
    // Reserved codes return the current source so it stays in effect
    function automatic hfc_pkg::hfc_src_e cpu_decode(
        input logic [2:0]        code,
        input hfc_pkg::hfc_src_e cur
    );
        case (code)
            3'h0:    cpu_decode = hfc_pkg::HFC_SRC_CPU;
            3'h2:    cpu_decode = hfc_pkg::HFC_SRC_AGENT1;
            3'h3:    cpu_decode = hfc_pkg::HFC_SRC_AGENT2;
            3'h4:    cpu_decode = hfc_pkg::HFC_SRC_AGENT3;
            3'h5:    cpu_decode = hfc_pkg::HFC_SRC_AGENT4;
            default: cpu_decode = cur;
        endcase
    endfunction

    function automatic hfc_pkg::hfc_src_e sys_decode(
        input logic [2:0]        code,
        input hfc_pkg::hfc_src_e cur
    );
        case (code)
            3'h0:    sys_decode = hfc_pkg::HFC_SRC_SYS;
            3'h1:    sys_decode = hfc_pkg::HFC_SRC_CPU;
            3'h4:    sys_decode = hfc_pkg::HFC_SRC_AGENT1;
            3'h5:    sys_decode = hfc_pkg::HFC_SRC_AGENT2;
            3'h6:    sys_decode = hfc_pkg::HFC_SRC_AGENT3;
            3'h7:    sys_decode = hfc_pkg::HFC_SRC_AGENT4;
            default: sys_decode = cur;
        endcase
    endfunction

    // ****************************************************************
    // Register update and read-back
    // ****************************************************************
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.rdata = 8'h00;
        if (wr_cpu) begin
            nxt_st.cpu_src_reg = wd[`HFC_CPU_SRC_LSB +: 3];
            nxt_st.cpu_src_eff = cpu_decode(wd[`HFC_CPU_SRC_LSB +: 3], st_ff.cpu_src_eff);
        end
        if (wr_sys) begin
            nxt_st.sys_src_reg = wd[`HFC_SYS_SRC_LSB +: 3];
            nxt_st.sys_src_eff = sys_decode(wd[`HFC_SYS_SRC_LSB +: 3], st_ff.sys_src_eff);
        end
        if (wr_adc) begin
            nxt_st.adc_sel    = wd[`HFC_ADC_SEL_LSB +: 2];
            // Stored as written; keeping them at 01 is up to software
            nxt_st.adc_rsv_hi = wd[`HFC_ADC_RSV_HI_LSB +: 2];
            nxt_st.adc_rsv_lo = wd[`HFC_ADC_RSV_LO_LSB +: 2];
        end
        if (wr_irq) begin
            nxt_st.cpu_irq_cmp  = wd[`HFC_CPU_IRQ_BIT];
            nxt_st.sys_one_shot = wd[`HFC_SYS_ONE_BIT];
            nxt_st.ovt_dis      = wd[`HFC_OVT_DIS_BIT];
            nxt_st.ovt_pol      = wd[`HFC_OVT_POL_BIT];
        end
        if (wr_fan) begin
            nxt_st.cpu_lvl = wd[`HFC_CPU_LVL_BIT];
            nxt_st.cpu_in  = wd[`HFC_CPU_IN_BIT];
            nxt_st.sys_lvl = wd[`HFC_SYS_LVL_BIT];
            nxt_st.sys_in  = wd[`HFC_SYS_IN_BIT];
        end
        if (bus.rd) begin
            case (bus.addr)
                `HFC_OFS_CPU_SRC: nxt_st.rdata = {5'h00, st_ff.cpu_src_reg};
                `HFC_OFS_SYS_SRC: nxt_st.rdata = {st_ff.sys_src_reg, 5'h00};
                `HFC_OFS_ADC_CLK: nxt_st.rdata = {st_ff.adc_rsv_hi, st_ff.adc_sel,
                                                  st_ff.adc_rsv_lo, 2'h0};
                `HFC_OFS_IRQ_OVT: nxt_st.rdata = {1'b0, st_ff.cpu_irq_cmp,
                                                  st_ff.sys_one_shot,
                                                  RST_IRQ[`HFC_IRQ_RSV_BIT],
                                                  st_ff.ovt_dis, st_ff.ovt_pol, 2'h0};
                `HFC_OFS_FAN_PIN: nxt_st.rdata = {4'h0, st_ff.cpu_lvl, st_ff.cpu_in,
                                                  st_ff.sys_lvl, st_ff.sys_in};
                default:          nxt_st.rdata = 8'h00;
            endcase
        end
        // Disabled channel shows the deasserted level of the chosen polarity
        nxt_st.ovt_pin  = (cpu_overtemp && !st_ff.ovt_dis) ? st_ff.ovt_pol
                                                          : !st_ff.ovt_pol;
        // A pin that is driven carries no tachometer pulses
        nxt_st.cpu_tach = st_ff.cpu_in && cpu_fan_tach_pin_i;
        nxt_st.sys_tach = st_ff.sys_in && system_fan_tach_pin_i;
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st_ff <= RST_ST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************************************
    // Converter clock
    // ****************************************************************
    always_comb begin
        case (st_ff.adc_sel)
            2'h0:    post_period = hfc_pkg::hfc_cnt_t'(`HFC_ADC_DIV_1);
            2'h1:    post_period = hfc_pkg::hfc_cnt_t'(`HFC_ADC_DIV_4);
            2'h2:    post_period = hfc_pkg::hfc_cnt_t'(`HFC_ADC_DIV_16);
            default: post_period = hfc_pkg::hfc_cnt_t'(`HFC_ADC_DIV_64);
        endcase
    end

    hfc_tick_div u_base_div (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .step    (1'b1),
        .period  (BASE_CYC),
        .tick    (base_tick)
    );

    hfc_tick_div u_post_div (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .step    (base_tick),
        .period  (post_period),
        .tick    (adc_sample_tick)
    );

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign rdata                       = st_ff.rdata;
    assign overtemp_pin                = st_ff.ovt_pin;
    assign cpu_fan_source_field        = st_ff.cpu_src_eff;
    assign system_fan_source_field     = st_ff.sys_src_eff;
    assign cpu_temp_irq_mode           = st_ff.cpu_irq_cmp;
    assign system_temp_one_shot_enable = st_ff.sys_one_shot;
    assign cpu_fan_tach_pin_oe         = !st_ff.cpu_in;
    assign cpu_fan_tach_pin_o          = st_ff.cpu_lvl;
    assign system_fan_tach_pin_oe      = !st_ff.sys_in;
    assign system_fan_tach_pin_o       = st_ff.sys_lvl;
    assign cpu_fan_tach                = st_ff.cpu_tach;
    assign system_fan_tach             = st_ff.sys_tach;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    hfc_pkg::hfc_cnt_t gap_q;
    logic              gap_seen_q;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            gap_q      <= '0;
            gap_seen_q <= 1'b0;
        end else if (base_tick) begin
            gap_q      <= '0;
            gap_seen_q <= 1'b1;
        end else begin
            gap_q <= hfc_pkg::hfc_cnt_t'(gap_q + 12'h001);
        end
    end

    sequence seq_wr_cpu_rsv;
        wr_cpu && (wd[`HFC_CPU_SRC_LSB +: 3] == 3'h1);
    endsequence

    sequence seq_wr_sys_rsv;
        wr_sys && (wd[`HFC_SYS_SRC_LSB +: 3] inside {3'h2, 3'h3});
    endsequence

    sequence seq_wr_fan;
        wr_fan;
    endsequence

    sequence seq_wr_irq;
        wr_irq;
    endsequence

    chk_cpu_src_keep: assert property (seq_wr_cpu_rsv |=> $stable(st_ff.cpu_src_eff))
        else $error("reserved cpu source code changed source");
    chk_cpu_src_agent: assert property (wr_cpu && (wd[2:0] == 3'h5)
        |=> cpu_fan_source_field == hfc_pkg::HFC_SRC_AGENT4)
        else $error("cpu source code 5 not agent 4");
    chk_sys_src_keep: assert property (seq_wr_sys_rsv |=> $stable(st_ff.sys_src_eff))
        else $error("reserved system source code changed source");
    chk_sys_src_cpu: assert property (wr_sys && (wd[7:5] == 3'h1)
        |=> system_fan_source_field == hfc_pkg::HFC_SRC_CPU)
        else $error("system source code 1 not cpu input");
    chk_adc_base_gap: assert property (base_tick && gap_seen_q
        |-> gap_q == hfc_pkg::hfc_cnt_t'(BASE_CYC - 12'h001))
        else $error("converter base period wrong");
    chk_adc_follows: assert property (adc_sample_tick |-> $past(base_tick))
        else $error("converter tick without base tick");
    chk_irq_modes: assert property (seq_wr_irq |=> (cpu_temp_irq_mode == $past(wd[6]))
        && (system_temp_one_shot_enable == $past(wd[5])))
        else $error("interrupt mode bits not taken");
    // Pin is registered from last cycle's polarity, so compare against that value
    chk_ovt_disabled: assert property (st_ff.ovt_dis && $stable(st_ff.ovt_pol)
        |=> overtemp_pin == !$past(st_ff.ovt_pol))
        else $error("disabled over-temperature still asserted");
    chk_ovt_polarity: assert property (cpu_overtemp && !st_ff.ovt_dis
        ##1 $stable(st_ff.ovt_pol) |-> overtemp_pin == st_ff.ovt_pol)
        else $error("over-temperature level wrong");
    chk_fan_pin_dir: assert property (seq_wr_fan |=> (cpu_fan_tach_pin_oe == !$past(wd[2]))
        && (system_fan_tach_pin_oe == !$past(wd[0])))
        else $error("fan pin direction not taken");
    chk_fan_pin_lvl: assert property (seq_wr_fan |=> (cpu_fan_tach_pin_o == $past(wd[3]))
        && (system_fan_tach_pin_o == $past(wd[1])))
        else $error("fan pin level not taken");
    chk_rsv_readback: assert property (bus.rd && (bus.addr == `HFC_OFS_IRQ_OVT)
        |=> (rdata[7] == 1'b0) && (rdata[4] == 1'b1) && (rdata[1:0] == 2'h0))
        else $error("reserved control bits read wrong");

endmodule

// File: testbench/hfc_regs_bench.sv
`timescale 1ns/1ns
`include "hfc_params.svh"

module hfc_regs_bench;
    logic               ref_clk;
    logic               rstn;
    hfc_pkg::hfc_bus_s  bus;
    logic [7:0]         rdata;
    logic               cpu_overtemp;
    logic               overtemp_pin;
    hfc_pkg::hfc_src_e  cpu_src;
    hfc_pkg::hfc_src_e  sys_src;
    logic               adc_sample_tick;
    logic               irq_mode;
    logic               one_shot;
    logic               cpu_pin_i;
    logic               cpu_pin_o;
    logic               cpu_pin_oe;
    logic               cpu_tach;
    logic               sys_pin_i;
    logic               sys_pin_o;
    logic               sys_pin_oe;
    logic               sys_tach;
    int                 miscompares;
    int                 checks;
    int                 seed;
    int                 cyc;
    int                 mreg [5];
    int                 msrc_cpu;
    int                 msrc_sys;
    logic [7:0]         ofs [5];

    hfc_regs i_dut (
        .ref_clk                     (ref_clk),
        .rstn                        (rstn),
        .bus                         (bus),
        .rdata                       (rdata),
        .cpu_overtemp                (cpu_overtemp),
        .overtemp_pin                (overtemp_pin),
        .cpu_fan_source_field        (cpu_src),
        .system_fan_source_field     (sys_src),
        .adc_sample_tick             (adc_sample_tick),
        .cpu_temp_irq_mode           (irq_mode),
        .system_temp_one_shot_enable (one_shot),
        .cpu_fan_tach_pin_i          (cpu_pin_i),
        .cpu_fan_tach_pin_o          (cpu_pin_o),
        .cpu_fan_tach_pin_oe         (cpu_pin_oe),
        .cpu_fan_tach                (cpu_tach),
        .system_fan_tach_pin_i       (sys_pin_i),
        .system_fan_tach_pin_o       (sys_pin_o),
        .system_fan_tach_pin_oe      (sys_pin_oe),
        .system_fan_tach             (sys_tach)
    );

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
    end

    // ****************************************************************
    // Reference model and checks
    // ****************************************************************
    // Stored bits per register; reserved bits outside the mask read zero, except bit 4 of register 3, which reads one
    function automatic void mwrite(input int i, input logic [7:0] d);
        logic [7:0] msk [5];
        int         c;
        msk = '{8'h07, 8'hE0, 8'hFC, 8'h6C, 8'h0F};
        mreg[i] = int'((d & msk[i]) | ((i == 3) ? 8'h10 : 8'h00));
        c = (i == 0) ? int'(d[2:0]) : int'(d[7:5]);
        if (i == 0 && c == 0) msrc_cpu = 0;
        if (i == 0 && c >= 2 && c <= 5) msrc_cpu = c;
        if (i == 1 && c <= 1) msrc_sys = 1 - c;
        if (i == 1 && c >= 4) msrc_sys = c - 2;
    endfunction

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        cmp_byte({7'h00, got}, {7'h00, exp}, what);
    endtask

    task automatic cmp_span(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("[ERR] %0t tick spacing %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge ref_clk);
        bus.wr    <= 1'b0;
        for (int i = 0; i < 5; i++) if (ofs[i] === a) mwrite(i, d);
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge ref_clk);
        bus.rd   <= 1'b0;
        #1;
        cmp_byte(rdata, exp, "read data");
    endtask

    task automatic settle;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    task automatic wait_tick(output int at);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (adc_sample_tick !== 1'b1 && n < 70000);
        if (n >= 70000) cmp_bit(1'b0, 1'b1, "no sample tick");
        at = cyc;
    endtask

    task automatic close_out;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Longest legal run is near 95k cycles, dominated by the slowest tick rate
    initial begin
        repeat (100000) @(posedge ref_clk);
        miscompares++;
        $display("[ERR] %0t watchdog expired", $time);
        close_out;
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        int         t0;
        int         t1;
        int         t2;
        logic [7:0] d;
        logic       ov;
        rstn = 1'b0;
        bus = '0;
        cpu_overtemp = 1'b0;
        cpu_pin_i = 1'b0;
        sys_pin_i = 1'b0;
        seed = 23977;
        cyc = 0;
        miscompares = 0;
        checks = 0;
        ofs = '{`HFC_OFS_CPU_SRC, `HFC_OFS_SYS_SRC, `HFC_OFS_ADC_CLK,
                `HFC_OFS_IRQ_OVT, `HFC_OFS_FAN_PIN};
        mreg = '{'h00, 'h00, 'h44, 'h10, 'h05};
        msrc_cpu = 0;
        msrc_sys = 1;
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        #1;
        t0 = cyc;
        cmp_bit(overtemp_pin, 1'b1, "idle overtemp level");
        cmp_bit(cpu_pin_oe, 1'b0, "cpu pin drive");
        cmp_bit(sys_pin_oe, 1'b0, "sys pin drive");
        wr(8'h4E, 8'($random(seed)));
        for (int i = 0; i < 5; i++) rd_chk(ofs[i], 8'(mreg[i]));
        rd_chk(8'h4E, 8'h00);
        $display("test reset values done");
        // Slowest rate counted from reset, so the divider phase is known
        wr(ofs[2], 8'h74);
        wait_tick(t1);
        cmp_span(t1 - t0, 63 * `HFC_ADC_BASE_CYC, 65 * `HFC_ADC_BASE_CYC);
        for (int s = 0; s < 3; s++) begin
            d = {2'($random(seed)), 2'(s), 2'b01, 2'($random(seed))};
            wr(ofs[2], d);
            rd_chk(ofs[2], 8'(mreg[2]));
            wait_tick(t1);
            wait_tick(t2);
            cmp_span(t2 - t1, `HFC_ADC_BASE_CYC << (2 * s), `HFC_ADC_BASE_CYC << (2 * s));
        end
        $display("test sample clock done");
        // Descending order puts each reserved code except cpu code 6 and system code 2 after a valid one
        for (int c = 7; c >= 0; c--) begin
            wr(ofs[0], {5'($random(seed)), 3'(c)});
            wr(ofs[1], {3'(c), 5'($random(seed))});
            settle;
            cmp_byte({5'h00, 3'(cpu_src)}, 8'(msrc_cpu), "cpu source");
            cmp_byte({5'h00, 3'(sys_src)}, 8'(msrc_sys), "sys source");
            rd_chk(ofs[0], 8'(mreg[0]));
            rd_chk(ofs[1], 8'(mreg[1]));
        end
        $display("test fan sources done");
        for (int v = 0; v < 16; v++) begin
            d = 8'($random(seed));
            d[6:5] = 2'(v >> 2);
            d[3:2] = 2'(v);
            wr(ofs[3], d);
            rd_chk(ofs[3], 8'(mreg[3]));
            for (int o = 0; o < 2; o++) begin
                ov = o[0];
                @(posedge ref_clk);
                cpu_overtemp <= ov;
                settle;
                cmp_bit(irq_mode, d[6], "cpu irq mode");
                cmp_bit(one_shot, d[5], "sys irq mode");
                cmp_bit(overtemp_pin, (ov & ~d[3]) ? d[2] : ~d[2], "overtemp pin");
            end
        end
        $display("test overtemp done");
        for (int v = 0; v < 16; v++) begin
            d = {4'($random(seed)), 4'(v)};
            wr(ofs[4], d);
            @(posedge ref_clk);
            cpu_pin_i <= 1'($random(seed));
            sys_pin_i <= 1'($random(seed));
            settle;
            cmp_bit(cpu_pin_oe, ~d[2], "cpu pin drive");
            if (!d[2]) cmp_bit(cpu_pin_o, d[3], "cpu pin level");
            cmp_bit(cpu_tach, d[2] & cpu_pin_i, "cpu tach");
            cmp_bit(sys_pin_oe, ~d[0], "sys pin drive");
            if (!d[0]) cmp_bit(sys_pin_o, d[1], "sys pin level");
            cmp_bit(sys_tach, d[0] & sys_pin_i, "sys tach");
            rd_chk(ofs[4], 8'(mreg[4]));
        end
        $display("test fan pins done");
        close_out;
    end
endmodule
